// [logic/pmcs_pkg.sv]
// Package of constants and types for the power mode clock selector
// Summary of operation
// - Gate CPU and pick source from control
// - Source 00 primary, 01 secondary, 1x internal
// - Source change switches at once when running
// - Sleep or Idle only on sleep instruction
// - Sleep with gate bit 0 stops CPU and peripheral clocks
// - Idle keeps peripherals, stops CPU, flags kept
// - Reset always enters primary run; two-speed acts only on sleep wake
// - Secondary run stops primary, sets secondary flag
// - Secondary entry waits for enable and ready
// - Internal run stops primary, clears ready flag
// - Internal frequency change applies immediately
// - Sleep entry stops oscillator, clears status flags
// - Watchdog keeps low oscillator; secondary stays enabled
// - Sleep wake waits ready or uses internal
// - Wake leaves gate bit unchanged; sleep wake takes the selected source if allowed
// - Idle exits only on interrupt, watchdog, reset
// - Idle wake delays CPU, resumes same source
// - Watchdog in Idle or Sleep wakes, no reset
// - Primary idle keeps primary running, flag set
// - Primary idle wake runs CPU after delay
// - Interrupt wake runs next instruction before vector
package pmcs_pkg;
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  localparam int SRC_HI_BIT = 1;
  localparam int FREQ_W = 3;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 3'h3;
  // Wake delay as a time and its cycle count at 40 MHz
  localparam int WAKE_DELAY_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_CYCLES = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] WAKE_CNT = CNT_W'(WAKE_CYCLES);

  typedef enum logic [1:0] {
    PMCS_RUN = 2'h0,
    PMCS_IDLE = 2'h1,
    PMCS_WAKE = 2'h3,
    PMCS_SLEEP = 2'h2
  } pmcs_mode_t;

  typedef struct packed {
    pmcs_mode_t mode;
    logic [1:0] src_active;
    logic pending_sec;
    logic [CNT_W-1:0] cnt;
    logic from_sleep;
    logic irq_wake;
    logic pri_ready_flag;
    logic sec_active_flag;
    logic [FREQ_W-1:0] freq;
  } pmcs_state_t;
endpackage

// [logic/pmcs_top.sv]
// Power mode and system clock source selector
`timescale 1ns/1ps
`default_nettype none
module pmcs_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control bits written by software
  input wire logic cpu_gate_on_sleep,
  input wire logic [1:0] clock_source_select,
  input wire logic [pmcs_pkg::FREQ_W-1:0] internal_freq_select,
  input wire logic secondary_osc_enable,
  input wire logic watchdog_enable,
  input wire logic two_speed_enable,
  input wire logic fail_safe_enable,
  input wire logic global_irq_enable,
  // CPU core events
  input wire logic sleep_instr,
  input wire logic irq_wake_req,
  input wire logic watchdog_timeout,
  // Oscillator ready flags from outside
  input wire logic primary_osc_ready_pin,
  input wire logic secondary_osc_ready_pin,
  // Clock gating and selection outputs
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic [1:0] sys_clk_sel,
  output logic [pmcs_pkg::FREQ_W-1:0] internal_freq,
  output logic primary_osc_en,
  output logic secondary_osc_run,
  output logic low_freq_internal_osc_en,
  // Status flags
  output logic primary_clock_ready_flag,
  output logic secondary_clock_active_flag,
  output logic in_sleep,
  output logic in_idle,
  // Wake handling toward the core
  output logic exec_next_instr,
  output logic vector_to_irq,
  output logic watchdog_reset
);

  pmcs_pkg::pmcs_state_t st_reg;
  pmcs_pkg::pmcs_state_t st_next;
  logic [1:0] pri_sync_reg;
  logic [1:0] sec_sync_reg;
  logic pri_rdy;
  logic sec_rdy;
  logic wake_evt;
  logic [1:0] want_src;
  logic src_ok;

  // Map a select value to the source it names
  function automatic logic [1:0] decode_src(input logic [1:0] sel);
    if (sel[pmcs_pkg::SRC_HI_BIT])
    begin
      decode_src = 2'h2;
    end
    else
    begin
      decode_src = sel;
    end
  endfunction

  // Two-stage synchronisers for the oscillator ready pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri_sync_reg <= 2'h0;
      sec_sync_reg <= 2'h0;
    end
    else
    begin
      pri_sync_reg <= {pri_sync_reg[0], primary_osc_ready_pin};
      sec_sync_reg <= {sec_sync_reg[0], secondary_osc_ready_pin};
    end
  end

  assign pri_rdy = pri_sync_reg[1];
  assign sec_rdy = sec_sync_reg[1];
  assign wake_evt = irq_wake_req | watchdog_timeout;
  assign want_src = decode_src(clock_source_select);
  // Secondary needs its enable and ready before it may take over
  assign src_ok = (want_src != pmcs_pkg::SRC_SECONDARY) || (secondary_osc_enable && sec_rdy);

  // Next-state logic for mode, source and flags
  always_comb
  begin
    st_next = st_reg;
    st_next.freq = internal_freq_select;
    case (st_reg.mode)
      pmcs_pkg::PMCS_RUN:
      begin
        // Source switch takes effect at once while running
        if (src_ok)
        begin
          st_next.src_active = want_src;
          st_next.pending_sec = 1'b0;
        end
        else
        begin
          st_next.pending_sec = 1'b1;
        end
        if (sleep_instr)
        begin
          // Mode depends on gate bit at the instruction
          st_next.irq_wake = 1'b0;
          if (cpu_gate_on_sleep)
          begin
            st_next.mode = pmcs_pkg::PMCS_IDLE;
          end
          else
          begin
            st_next.mode = pmcs_pkg::PMCS_SLEEP;
            st_next.pri_ready_flag = 1'b0;
            st_next.sec_active_flag = 1'b0;
          end
        end
        else
        begin
          st_next.sec_active_flag = (st_next.src_active == pmcs_pkg::SRC_SECONDARY);
          st_next.pri_ready_flag = (st_next.src_active == pmcs_pkg::SRC_PRIMARY) && pri_rdy;
        end
      end
      pmcs_pkg::PMCS_IDLE:
      begin
        // Flags stay as they were; only wake events leave
        if (wake_evt)
        begin
          st_next.mode = pmcs_pkg::PMCS_WAKE;
          st_next.cnt = pmcs_pkg::WAKE_CNT;
          st_next.from_sleep = 1'b0;
          st_next.irq_wake = irq_wake_req;
        end
      end
      pmcs_pkg::PMCS_SLEEP:
      begin
        if (wake_evt)
        begin
          st_next.mode = pmcs_pkg::PMCS_WAKE;
          st_next.cnt = pmcs_pkg::WAKE_CNT;
          st_next.from_sleep = 1'b1;
          st_next.irq_wake = irq_wake_req;
          // Source follows the select if allowed, else keeps the old one
          st_next.src_active = src_ok ? want_src : st_reg.src_active;
        end
      end
      pmcs_pkg::PMCS_WAKE:
      begin
        // Delay counts while the clock is up
        if (cpu_clk_gate_ok(st_reg, pri_rdy, sec_rdy, two_speed_enable, fail_safe_enable))
        begin
          if (st_reg.cnt <= 8'h01)
          begin
            st_next.mode = pmcs_pkg::PMCS_RUN;
            st_next.cnt = 8'h00;
          end
          else
          begin
            st_next.cnt = st_reg.cnt - 8'h01;
          end
        end
        st_next.pri_ready_flag = (st_reg.src_active == pmcs_pkg::SRC_PRIMARY) && pri_rdy;
        st_next.sec_active_flag = (st_reg.src_active == pmcs_pkg::SRC_SECONDARY);
      end
      default:
      begin
        st_next.mode = pmcs_pkg::PMCS_RUN;
      end
    endcase
  end

  // True when the clock tree may run during wake-up
  function automatic logic cpu_clk_gate_ok(input pmcs_pkg::pmcs_state_t s, input logic prdy,
    input logic srdy, input logic tse, input logic fse);
    logic rdy;
    rdy = 1'b1;
    if (s.src_active == pmcs_pkg::SRC_PRIMARY)
    begin
      rdy = prdy;
    end
    else if (s.src_active == pmcs_pkg::SRC_SECONDARY)
    begin
      rdy = srdy;
    end
    cpu_clk_gate_ok = !s.from_sleep || rdy || tse || fse;
  endfunction

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.freq <= pmcs_pkg::FREQ_RESET;
      st_reg.mode <= pmcs_pkg::PMCS_RUN;
      st_reg.src_active <= pmcs_pkg::SRC_PRIMARY;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Wake-up from sleep with two-speed or fail-safe runs from internal block while the selected source is not ready
  logic wake_on_internal;
  assign wake_on_internal = (st_reg.mode == pmcs_pkg::PMCS_WAKE) && st_reg.from_sleep &&
    (two_speed_enable || fail_safe_enable) &&
    !cpu_clk_src_ready(st_reg.src_active, pri_rdy, sec_rdy);

  function automatic logic cpu_clk_src_ready(input logic [1:0] s, input logic p, input logic q);
    cpu_clk_src_ready = (s == pmcs_pkg::SRC_PRIMARY) ? p :
      ((s == pmcs_pkg::SRC_SECONDARY) ? q : 1'b1);
  endfunction

  // Outputs
  assign cpu_clk_en = (st_reg.mode == pmcs_pkg::PMCS_RUN);
  assign periph_clk_en = (st_reg.mode == pmcs_pkg::PMCS_RUN) || (st_reg.mode == pmcs_pkg::PMCS_IDLE) ||
    ((st_reg.mode == pmcs_pkg::PMCS_WAKE) &&
    cpu_clk_gate_ok(st_reg, pri_rdy, sec_rdy, two_speed_enable, fail_safe_enable));
  assign sys_clk_sel = wake_on_internal ? 2'h2 : st_reg.src_active;
  assign internal_freq = st_reg.freq;
  // Primary stops when not selected and during sleep; kept in primary idle
  assign primary_osc_en = (st_reg.src_active == pmcs_pkg::SRC_PRIMARY) &&
    (st_reg.mode != pmcs_pkg::PMCS_SLEEP);
  assign secondary_osc_run = secondary_osc_enable;
  assign low_freq_internal_osc_en = watchdog_enable || fail_safe_enable ||
    (st_reg.mode == pmcs_pkg::PMCS_RUN && st_reg.src_active == 2'h2);
  assign primary_clock_ready_flag = st_reg.pri_ready_flag;
  assign secondary_clock_active_flag = st_reg.sec_active_flag;
  assign in_sleep = (st_reg.mode == pmcs_pkg::PMCS_SLEEP);
  assign in_idle = (st_reg.mode == pmcs_pkg::PMCS_IDLE);
  // Interrupt wake: next instruction first, then vector if enabled
  assign exec_next_instr = (st_reg.mode == pmcs_pkg::PMCS_WAKE) && (st_next.mode == pmcs_pkg::PMCS_RUN);
  assign vector_to_irq = exec_next_instr && st_reg.irq_wake && global_irq_enable;
  // Watchdog only resets while the CPU runs
  assign watchdog_reset = watchdog_timeout && (st_reg.mode == pmcs_pkg::PMCS_RUN);

endmodule
`default_nettype wire

// [tb/pmcs_properties.sv]
// Concurrent checks on the power mode clock selector ports
`timescale 1ns/1ps
`default_nettype none
module pmcs_properties
(
  // Clock, reset and control inputs
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_gate_on_sleep,
  input wire logic global_irq_enable,
  input wire logic sleep_instr,
  input wire logic irq_wake_req,
  input wire logic watchdog_timeout,
  // Outputs watched
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic primary_clock_ready_flag,
  input wire logic secondary_clock_active_flag,
  input wire logic in_sleep,
  input wire logic in_idle,
  input wire logic exec_next_instr,
  input wire logic vector_to_irq,
  input wire logic watchdog_reset
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Wake event in Idle, then the CPU held off for the wake count
  sequence s_idle_wake;
    in_idle && (irq_wake_req || watchdog_timeout);
  endsequence
  sequence s_cpu_held;
    !cpu_clk_en [*8] ##32 exec_next_instr ##1 cpu_clk_en;
  endsequence
  property p_wake; s_idle_wake |=> s_cpu_held; endproperty
  a_wake: assert property (p_wake) else $error("idle wake timing wrong");
  property p_idle; sleep_instr && cpu_clk_en && cpu_gate_on_sleep |=> in_idle && periph_clk_en; endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  property p_sleep; sleep_instr && cpu_clk_en && !cpu_gate_on_sleep |=> in_sleep && !periph_clk_en; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_sflag; in_sleep |-> !primary_clock_ready_flag && !secondary_clock_active_flag; endproperty
  a_sflag: assert property (p_sflag) else $error("flags set in sleep");
  property p_cause; $rose(in_idle || in_sleep) |-> $past(sleep_instr) && !cpu_clk_en; endproperty
  a_cause: assert property (p_cause) else $error("low power without sleep");
  property p_stay; in_idle && !irq_wake_req && !watchdog_timeout |=> in_idle; endproperty
  a_stay: assert property (p_stay) else $error("idle left without event");
  property p_vec; vector_to_irq |-> exec_next_instr && global_irq_enable; endproperty
  a_vec: assert property (p_vec) else $error("vector without next instruction");
  property p_wdt; watchdog_reset == (watchdog_timeout && cpu_clk_en); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset wrong");
endmodule
bind pmcs_top pmcs_properties i_pmcs_properties (.clk, .rst_n, .cpu_gate_on_sleep,
  .global_irq_enable, .sleep_instr, .irq_wake_req, .watchdog_timeout, .cpu_clk_en,
  .periph_clk_en, .primary_clock_ready_flag, .secondary_clock_active_flag, .in_sleep,
  .in_idle, .exec_next_instr, .vector_to_irq, .watchdog_reset);
`default_nettype wire

// [tb/pmcs_osc_model.sv]
// Oscillator sources answering the selector with ready levels
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enables from the selector
  input wire logic primary_osc_en,
  input wire logic secondary_osc_run,
  // Ready levels
  output logic primary_osc_ready_pin,
  output logic secondary_osc_ready_pin
);
  logic [3:0] pri_sh;
  logic [3:0] sec_sh;
  // Ready rises four cycles after start, drops at once on stop
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      pri_sh <= 4'h0;
      sec_sh <= 4'h0;
    end
    else
    begin
      pri_sh <= primary_osc_en ? {pri_sh[2:0], 1'b1} : 4'h0;
      sec_sh <= secondary_osc_run ? {sec_sh[2:0], 1'b1} : 4'h0;
    end
  assign primary_osc_ready_pin = pri_sh[3] & primary_osc_en;
  assign secondary_osc_ready_pin = sec_sh[3] & secondary_osc_run;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the power mode clock selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_n, cpu_gate_on_sleep, secondary_osc_enable, watchdog_enable;
  logic two_speed_enable, fail_safe_enable, global_irq_enable, sleep_instr;
  logic irq_wake_req, watchdog_timeout, primary_osc_ready_pin, secondary_osc_ready_pin;
  logic cpu_clk_en, periph_clk_en, primary_osc_en, secondary_osc_run, in_sleep, in_idle;
  logic low_freq_internal_osc_en, primary_clock_ready_flag, secondary_clock_active_flag;
  logic exec_next_instr, vector_to_irq, watchdog_reset;
  logic [1:0] clock_source_select, sys_clk_sel;
  logic [pmcs_pkg::FREQ_W-1:0] internal_freq_select, internal_freq;
  int fails, comparisons, n;
  // Rows: select, secondary enable, expected source, primary flag, secondary flag
  logic [6:0] rows [6] = '{7'h02, 7'h22, 7'h35, 7'h78, 7'h48, 7'h02};
  pmcs_top i_pmcs_top (.clk, .rst_n, .cpu_gate_on_sleep, .clock_source_select,
    .internal_freq_select, .secondary_osc_enable, .watchdog_enable, .two_speed_enable,
    .fail_safe_enable, .global_irq_enable, .sleep_instr, .irq_wake_req, .watchdog_timeout,
    .primary_osc_ready_pin, .secondary_osc_ready_pin, .cpu_clk_en, .periph_clk_en,
    .sys_clk_sel, .internal_freq, .primary_osc_en, .secondary_osc_run,
    .low_freq_internal_osc_en, .primary_clock_ready_flag, .secondary_clock_active_flag,
    .in_sleep, .in_idle, .exec_next_instr, .vector_to_irq, .watchdog_reset);
  pmcs_osc_model i_pmcs_osc_model (.clk, .rst_n, .primary_osc_en, .secondary_osc_run,
    .primary_osc_ready_pin, .secondary_osc_ready_pin);
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Bounded wait for the last wake cycle
  task automatic wait_exec();
    n = 0;
    while (exec_next_instr !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic sleep_cmd();
    sleep_instr = 1'b1;
    tick(1);
    sleep_instr = 1'b0;
    tick(1);
  endtask
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog against a hang
  initial
  begin
    #(25 * 2000);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    {rst_n, cpu_gate_on_sleep, secondary_osc_enable, watchdog_enable, two_speed_enable} = '0;
    {fail_safe_enable, global_irq_enable, sleep_instr, irq_wake_req, watchdog_timeout} = '0;
    clock_source_select = 2'h0;
    internal_freq_select = 3'h3;
    tick(6);
    rst_n = 1'b1;
    chk(8'({cpu_clk_en, periph_clk_en, in_idle, in_sleep, sys_clk_sel}), 8'h30);
    foreach (rows[i])
    begin
      {clock_source_select, secondary_osc_enable} = rows[i][6:4];
      internal_freq_select = 3'(i);
      tick(16);
      chk(8'(sys_clk_sel), 8'(rows[i][3:2]));
      chk(8'({primary_clock_ready_flag, secondary_clock_active_flag}), 8'(rows[i][1:0]));
      chk(8'(internal_freq), 8'(i));
    end
    // Primary idle, interrupt wake with vectoring
    cpu_gate_on_sleep = 1'b1;
    global_irq_enable = 1'b1;
    sleep_cmd();
    tick(5);
    chk(8'({in_idle, cpu_clk_en, periph_clk_en, primary_osc_en, primary_clock_ready_flag}), 8'h17);
    irq_wake_req = 1'b1;
    tick(1);
    irq_wake_req = 1'b0;
    wait_exec();
    chk(8'(n), 8'(pmcs_pkg::WAKE_CYCLES - 1));
    chk(8'({vector_to_irq, cpu_clk_en}), 8'h2);
    tick(1);
    chk(8'({cpu_clk_en, sys_clk_sel}), 8'h4);
    // Sleep, watchdog wake without reset
    {cpu_gate_on_sleep, global_irq_enable} = 2'h0;
    {watchdog_enable, secondary_osc_enable} = 2'h3;
    sleep_cmd();
    tick(1);
    chk(8'({in_sleep, periph_clk_en, primary_clock_ready_flag, secondary_clock_active_flag}), 8'h8);
    chk(8'({primary_osc_en, secondary_osc_run, low_freq_internal_osc_en}), 8'h3);
    watchdog_timeout = 1'b1;
    tick(1);
    chk(8'({watchdog_reset, in_sleep}), 8'h0);
    watchdog_timeout = 1'b0;
    wait_exec();
    chk(8'({exec_next_instr, vector_to_irq}), 8'h2);
    tick(10);
    chk(8'({cpu_clk_en, sys_clk_sel, primary_clock_ready_flag}), 8'h9);
    watchdog_timeout = 1'b1;
    #1;
    chk(8'(watchdog_reset), 8'h1);
    tick(1);
    watchdog_timeout = 1'b0;
    // Secondary idle: gate bit first, then select 01, then sleep; wake without vector
    cpu_gate_on_sleep = 1'b1;
    tick(1);
    clock_source_select = 2'h1;
    tick(2);
    sleep_cmd();
    chk(8'({in_idle, cpu_clk_en, periph_clk_en, sys_clk_sel}), 8'h15);
    chk(8'({secondary_clock_active_flag, primary_clock_ready_flag}), 8'h2);
    irq_wake_req = 1'b1;
    tick(1);
    irq_wake_req = 1'b0;
    wait_exec();
    chk(8'({exec_next_instr, vector_to_irq}), 8'h2);
    tick(1);
    chk(8'({cpu_clk_en, sys_clk_sel, secondary_clock_active_flag}), 8'hB);
    // Back to primary, then sleep with two-speed start-up and wake on the internal block
    {cpu_gate_on_sleep, clock_source_select} = 3'h0;
    two_speed_enable = 1'b1;
    tick(10);
    sleep_cmd();
    tick(2);
    watchdog_timeout = 1'b1;
    tick(1);
    watchdog_timeout = 1'b0;
    chk(8'({sys_clk_sel, periph_clk_en, cpu_clk_en, primary_clock_ready_flag}), 8'h14);
    wait_exec();
    chk(8'(n), 8'(pmcs_pkg::WAKE_CYCLES - 1));
    tick(1);
    chk(8'({cpu_clk_en, sys_clk_sel, primary_clock_ready_flag}), 8'h9);
    // Reset in mid-run from primary idle
    two_speed_enable = 1'b0;
    cpu_gate_on_sleep = 1'b1;
    sleep_cmd();
    rst_n = 1'b0;
    tick(2);
    chk(8'({cpu_clk_en, periph_clk_en, in_idle, in_sleep, sys_clk_sel}), 8'h30);
    chk(8'({primary_clock_ready_flag, secondary_clock_active_flag}), 8'h0);
    chk(8'(internal_freq), 8'(pmcs_pkg::FREQ_RESET));
    rst_n = 1'b1;
    cpu_gate_on_sleep = 1'b0;
    tick(10);
    chk(8'({cpu_clk_en, sys_clk_sel, primary_clock_ready_flag}), 8'h9);
    give_verdict();
  end
endmodule
`default_nettype wire
